// file: iroc_regs.svh
// Register offsets, reset values and source codes of the input routing and output control block
`ifndef IROC_REGS_SVH
`define IROC_REGS_SVH

// APB byte offsets, one aligned word each
`define IROC_OFS_IN_MAP_EN   12'h000
`define IROC_OFS_SF_EN       12'h004
`define IROC_OFS_IN_INVERT   12'h008
`define IROC_OFS_FORCE_EN    12'h00c
`define IROC_OFS_FORCE_VAL   12'h010
`define IROC_OFS_IN_RAW      12'h014
`define IROC_OFS_IN_IMAGE    12'h018
`define IROC_OFS_OUT_IMAGE   12'h01c
`define IROC_OFS_OUT_UNUSED  12'h020
`define IROC_OFS_OUT_POL     12'h024
`define IROC_OFS_MAN_EN      12'h028
`define IROC_OFS_MAN_VAL     12'h02c
`define IROC_OFS_APPLIED     12'h030
`define IROC_OFS_OUT_MAP_EN  12'h034
// Source table: entry n at 0x100 + 4*(n-1); page is paddr[11:7]
`define IROC_TBL_PAGE        5'h02

// Reset values
`define IROC_RST_MAP_EN      8'h00
`define IROC_RST_WORD        32'h0000_0000
`define IROC_RST_CODE        8'h00

// Mapping enable value that switches mapping on
`define IROC_MAP_ON          8'h01

// Source codes (low seven bits; bit 7 inverts)
`define IROC_CODE_ZERO       7'h00
`define IROC_CODE_PHYS_LAST  7'h10
`define IROC_CODE_AUX_FIRST  7'h41
`define IROC_CODE_AUX_LAST   7'h48
`define IROC_CODE_INV        8'h80

// Image bit positions
`define IROC_LEVEL_BASE      16
`define IROC_BIT_BRAKE       0
`define IROC_SF_COUNT        3

`endif

// file: iroc_pkg.sv
// Types shared by the input routing and output control block
package iroc_pkg;

    // Every source that a mapping entry can select, in code order
    typedef struct packed {
        logic        eth_active;
        logic        usb_power;
        logic        enc_index;
        logic        enc_b;
        logic        enc_a;
        logic        hall_w;
        logic        hall_v;
        logic        hall_u;
        logic [15:0] phys;
    } iroc_src_t;

    // Output configuration words gathered for the output stage
    typedef struct packed {
        logic [31:0] image;
        logic [31:0] polarity;
        logic [31:0] man_en;
        logic [31:0] man_val;
    } iroc_out_cfg_t;

endpackage

// file: iroc_sync.sv
// Two-stage synchroniser for a bundle of asynchronous level inputs
`timescale 1ns/1ps

module iroc_sync #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// file: iroc_src_mux.sv
// Decodes one source code into the selected, optionally inverted, source level
`include "iroc_regs.svh"
`timescale 1ns/1ps

module iroc_src_mux (
    // Selection
    input  wire logic [7:0]        code,
    input  wire iroc_pkg::iroc_src_t src,
    // Result
    output logic                   level
);

    logic [6:0] sel;
    logic [6:0] phys_idx;
    logic [6:0] aux_idx;
    logic [7:0] aux_vec;
    logic       raw;

    assign sel      = code[6:0];
    assign phys_idx = sel - 7'h01;
    assign aux_idx  = sel - `IROC_CODE_AUX_FIRST;
    assign aux_vec  = {src.eth_active, src.usb_power, src.enc_index, src.enc_b,
                       src.enc_a, src.hall_w, src.hall_v, src.hall_u};

    // Undefined codes read as zero so a bad table entry without bit 7 stays quiet
    always_comb begin
        raw = 1'b0;
        if (sel == `IROC_CODE_ZERO) begin
            raw = 1'b0;
        end else if (sel <= `IROC_CODE_PHYS_LAST) begin
            raw = src.phys[phys_idx[3:0]];
        end else if (sel >= `IROC_CODE_AUX_FIRST && sel <= `IROC_CODE_AUX_LAST) begin
            raw = aux_vec[aux_idx[2:0]];
        end
    end

    // Bit 7 selects the inverted form
    assign level = raw ^ code[7];

endmodule

// file: iroc_top.sv
// Input routing onto the input image and output control from the output image, APB slave
`include "iroc_regs.svh"
`timescale 1ns/1ps

// Operation
// - Mapping active only when enable equals one
// - Mapping on ignores function, invert, force settings
// - Enabling mapping preloads table with prior behaviour; preload ignores force, so forced inputs lose their force
// - Entry n drives input image bit n-1
// - Code zero is zero; 1..16 physical inputs
// - Codes 41..46 select Hall and encoder lines
// - Code 47 USB power, 48 Ethernet activity
// - Adding 80 selects inverted source
// - Output image bit 16 drives output one
// - Bits 0..15 special; bit 0 brake
// - Output settings act per bit only
// - Polarity bit selects normally open or closed
// - Manual control takes level from manual value
// - Manual value holds level per output
// - Applied output pattern is readable
// - Output mapping enable hands outputs to routing
module iroc_top #(
    parameter int N_OUT = 4,
    parameter int N_MAP = 32
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Field sources, asynchronous
    input  wire logic [15:0]      phys_in,
    input  wire logic [2:0]       hall_in,
    input  wire logic [2:0]       enc_in,
    input  wire logic             usb_power_in,
    input  wire logic             eth_active_in,
    // Levels from the output routing logic, same clock
    input  wire logic [N_OUT-1:0] route_level,
    // Input image to the firmware side
    output logic      [31:0]      in_image,
    // Field outputs
    output logic                  brake_out,
    output logic      [N_OUT-1:0] dout,
    output logic                  out_map_active
);

    // Synchronised sources
    logic [23:0]         src_sync;
    iroc_pkg::iroc_src_t src;

    // Software registers
    logic [7:0]  in_map_en_q;
    logic [31:0] sf_en_q;
    logic [31:0] in_inv_q;
    logic [31:0] force_en_q;
    logic [31:0] force_val_q;
    logic [31:0] out_image_q;
    logic [31:0] out_pol_q;
    logic [31:0] man_en_q;
    logic [31:0] man_val_q;
    logic [7:0]  out_map_en_q;
    logic [7:0]  tbl_q [N_MAP];

    // Derived state
    logic        map_on;
    logic [31:0] raw_word;
    logic [31:0] norm_image;
    logic [31:0] map_image;
    logic [31:0] image_d;
    logic [31:0] applied_d;
    logic [31:0] applied_q;
    iroc_pkg::iroc_out_cfg_t out_cfg;

    // Bus decode
    logic        setup;
    logic        wr_acc;
    logic        tbl_hit;
    logic [4:0]  tbl_idx;
    logic        preload;
    logic [31:0] rd_d;
    logic        err_d;

    // Every source passes two flops before anything selects it
    iroc_sync #(
        .WIDTH    (24)
    ) u_sync (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .async_in ({eth_active_in, usb_power_in, enc_in, hall_in, phys_in}),
        .sync_out (src_sync)
    );

    assign src = iroc_pkg::iroc_src_t'(src_sync);

    // APB phases; access completes on the edge where pready is high
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pready & pwrite;
    assign tbl_hit = (paddr[11:7] == `IROC_TBL_PAGE);
    assign tbl_idx = paddr[6:2];

    // Mapping counts as on only for the exact enable value
    assign map_on = (in_map_en_q == `IROC_MAP_ON);

    // Switching mapping on rewrites the table from the current settings
    assign preload = wr_acc & ~tbl_hit & (paddr == `IROC_OFS_IN_MAP_EN)
                   & (pwdata[7:0] == `IROC_MAP_ON) & ~map_on;

    // Input mapping enable
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            in_map_en_q <= `IROC_RST_MAP_EN;
        end else if (wr_acc && paddr == `IROC_OFS_IN_MAP_EN) begin
            in_map_en_q <= pwdata[7:0];
        end
    end

    // Input path settings, kept even while mapping ignores them
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sf_en_q     <= `IROC_RST_WORD;
            in_inv_q    <= `IROC_RST_WORD;
            force_en_q  <= `IROC_RST_WORD;
            force_val_q <= `IROC_RST_WORD;
        end else if (wr_acc) begin
            case (paddr)
                `IROC_OFS_SF_EN:     sf_en_q     <= pwdata;
                `IROC_OFS_IN_INVERT: in_inv_q    <= pwdata;
                `IROC_OFS_FORCE_EN:  force_en_q  <= pwdata;
                `IROC_OFS_FORCE_VAL: force_val_q <= pwdata;
                default: begin
                end
            endcase
        end
    end

    // Output settings
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_image_q  <= `IROC_RST_WORD;
            out_pol_q    <= `IROC_RST_WORD;
            man_en_q     <= `IROC_RST_WORD;
            man_val_q    <= `IROC_RST_WORD;
            out_map_en_q <= `IROC_RST_MAP_EN;
        end else if (wr_acc) begin
            case (paddr)
                `IROC_OFS_OUT_IMAGE:  out_image_q  <= pwdata;
                `IROC_OFS_OUT_POL:    out_pol_q    <= pwdata;
                `IROC_OFS_MAN_EN:     man_en_q     <= pwdata;
                `IROC_OFS_MAN_VAL:    man_val_q    <= pwdata;
                `IROC_OFS_OUT_MAP_EN: out_map_en_q <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Source table; preload gives each image bit the code of its old meaning.
    // Force cannot be expressed as a code, so forced inputs lose their force.
    generate
        for (genvar n = 0; n < N_MAP; n++) begin : g_tbl
            logic [7:0] pre_code;

            if (n >= `IROC_LEVEL_BASE) begin : g_level
                assign pre_code = {in_inv_q[n - `IROC_LEVEL_BASE], 7'(n - `IROC_LEVEL_BASE + 1)};
            end else if (n < `IROC_SF_COUNT) begin : g_sf
                assign pre_code = sf_en_q[n] ? {in_inv_q[n], 7'(n + 1)} : `IROC_RST_CODE;
            end else begin : g_none
                assign pre_code = `IROC_RST_CODE;
            end

            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    tbl_q[n] <= `IROC_RST_CODE;
                end else if (preload) begin
                    tbl_q[n] <= pre_code;
                end else if (wr_acc && tbl_hit && tbl_idx == 5'(n)) begin
                    tbl_q[n] <= pwdata[7:0];
                end
            end

            // Entry at index n (subindex n+1) feeds image bit n
            iroc_src_mux u_mux (
                .code  (tbl_q[n]),
                .src   (src),
                .level (map_image[n])
            );
        end
    endgenerate

    // Normal path: level bits from invert and force, special bits gated by enable
    assign raw_word = {src.phys, 16'h0000};

    always_comb begin
        norm_image = 32'h0000_0000;
        for (int i = 0; i < 16; i++) begin
            norm_image[i + `IROC_LEVEL_BASE] = force_en_q[i] ? force_val_q[i] : (src.phys[i] ^ in_inv_q[i]);
        end
        for (int i = 0; i < `IROC_SF_COUNT; i++) begin
            norm_image[i] = sf_en_q[i] & norm_image[i + `IROC_LEVEL_BASE];
        end
    end

    // Mapping on hides all four input settings
    assign image_d = map_on ? map_image : norm_image;

    // Input image register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            in_image <= `IROC_RST_WORD;
        end else begin
            in_image <= image_d;
        end
    end

    // Output stage configuration bundle
    assign out_cfg = '{image: out_image_q, polarity: out_pol_q, man_en: man_en_q, man_val: man_val_q};

    // Each bit works alone: manual override, else image through polarity
    always_comb begin
        applied_d = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            if (out_cfg.man_en[i]) begin
                applied_d[i] = out_cfg.man_val[i];
            end else begin
                applied_d[i] = out_cfg.image[i] ^ out_cfg.polarity[i];
            end
        end
        // Routing owns the level outputs; brake stays on the normal path
        if (out_map_en_q == `IROC_MAP_ON) begin
            applied_d[`IROC_LEVEL_BASE +: N_OUT] = route_level;
        end
        // Unassigned special bits never reach a pin
        applied_d[15:1] = 15'h0000;
    end

    // Applied pattern and pin drivers, all from flops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            applied_q      <= `IROC_RST_WORD;
            brake_out      <= 1'b0;
            dout           <= '0;
            out_map_active <= 1'b0;
        end else begin
            applied_q      <= applied_d;
            brake_out      <= applied_d[`IROC_BIT_BRAKE];
            dout           <= applied_d[`IROC_LEVEL_BASE +: N_OUT];
            out_map_active <= (out_map_en_q == `IROC_MAP_ON);
        end
    end

    // Read mux; unmapped offsets read zero with an error
    always_comb begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (tbl_hit) begin
            rd_d = {24'h000000, tbl_q[tbl_idx]};
        end else begin
            case (paddr)
                `IROC_OFS_IN_MAP_EN:  rd_d = {24'h000000, in_map_en_q};
                `IROC_OFS_SF_EN:      rd_d = sf_en_q;
                `IROC_OFS_IN_INVERT:  rd_d = in_inv_q;
                `IROC_OFS_FORCE_EN:   rd_d = force_en_q;
                `IROC_OFS_FORCE_VAL:  rd_d = force_val_q;
                `IROC_OFS_IN_RAW:     rd_d = raw_word;
                `IROC_OFS_IN_IMAGE:   rd_d = in_image;
                `IROC_OFS_OUT_IMAGE:  rd_d = out_image_q;
                `IROC_OFS_OUT_UNUSED: rd_d = 32'h0000_0000;
                `IROC_OFS_OUT_POL:    rd_d = out_pol_q;
                `IROC_OFS_MAN_EN:     rd_d = man_en_q;
                `IROC_OFS_MAN_VAL:    rd_d = man_val_q;
                `IROC_OFS_APPLIED:    rd_d = applied_q;
                `IROC_OFS_OUT_MAP_EN: rd_d = {24'h000000, out_map_en_q};
                default:              err_d = 1'b1;
            endcase
        end
    end

    // Answer prepared at setup so the access phase always takes one cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & err_d;
            if (setup && !pwrite) begin
                prdata <= rd_d;
            end
        end
    end

endmodule

// file: iroc_field.sv
// Field wiring model that drives the asynchronous source levels of the block
`timescale 1ns/1ps

module iroc_field (
    // Levels chosen by the bench, in source code order from physical input 1 upward
    input  wire logic [23:0] lvl,
    // Wiring into the block
    output logic      [15:0] phys_in,
    output logic      [2:0]  hall_in,
    output logic      [2:0]  enc_in,
    output logic             usb_power_in,
    output logic             eth_active_in
);
    // Plain wires with no clock of their own, so the block must synchronise every line
    assign {eth_active_in, usb_power_in, enc_in, hall_in, phys_in} = lvl;
endmodule

// file: iroc_top_sva.sv
// Port-level assertions of the input routing and output control block
`timescale 1ns/1ps
`include "iroc_regs.svh"

module iroc_top_sva #(
    parameter int N_OUT = 4,
    parameter int N_MAP = 32
) (
    // Clock and reset
    input wire logic             sys_clk,
    input wire logic             srst,
    // APB
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // Field sources and outputs
    input wire logic [15:0]      phys_in,
    input wire logic [2:0]       hall_in,
    input wire logic [2:0]       enc_in,
    input wire logic             usb_power_in,
    input wire logic             eth_active_in,
    input wire logic [N_OUT-1:0] route_level,
    input wire logic [31:0]      in_image,
    input wire logic [N_OUT-1:0] dout,
    input wire logic             out_map_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Decoded register space; aligned addresses only
    function automatic logic mapped(input logic [11:0] a);
        return (a <= `IROC_OFS_OUT_MAP_EN) || (a[11:7] == `IROC_TBL_PAGE);
    endfunction

    // Transfer steps and a quiet spell with neither bus traffic nor source changes
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    sequence s_quiet; !psel && $stable({phys_in, hall_in, enc_in, usb_power_in, eth_active_in}); endsequence

    a_ready_follows: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside an access phase");
    a_err_decode: assert property (s_setup ##1 s_access |-> pslverr == !mapped(paddr))
        else $error("pslverr does not match the address decode");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata changed without a read setup");
    a_route_follow: assert property (out_map_active && $past(out_map_active) |-> dout == $past(route_level))
        else $error("outputs do not follow the routing levels");
    a_map_flag: assert property (psel && penable && pready && pwrite && paddr == `IROC_OFS_OUT_MAP_EN
        |-> ##2 out_map_active == ($past(pwdata[7:0], 2) == `IROC_MAP_ON))
        else $error("output mapping flag wrong after write");
    a_in_quiet: assert property (s_quiet [*5] |-> $stable(in_image))
        else $error("input image moved with no cause");
endmodule

bind iroc_top iroc_top_sva #(.N_OUT(N_OUT), .N_MAP(N_MAP)) i_sva (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .phys_in(phys_in),
    .hall_in(hall_in), .enc_in(enc_in), .usb_power_in(usb_power_in), .eth_active_in(eth_active_in),
    .route_level(route_level), .in_image(in_image), .dout(dout), .out_map_active(out_map_active));

// file: tb.sv
// Self-checking bench of the input routing and output control block
`timescale 1ns/1ps
`include "iroc_regs.svh"

module tb;
    localparam int N_OUT = 4;
    logic             sys_clk = 1'b0;
    logic             srst    = 1'b1;
    logic             psel    = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite  = 1'b0;
    logic [11:0]      paddr   = 12'h000;
    logic [31:0]      pwdata  = 32'h0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [23:0]      lvl     = 24'h0;
    logic [15:0]      phys_in;
    logic [2:0]       hall_in;
    logic [2:0]       enc_in;
    logic             usb_power_in;
    logic             eth_active_in;
    logic [N_OUT-1:0] route   = 4'h0;
    logic [31:0]      in_image;
    logic             brake_out;
    logic [N_OUT-1:0] dout;
    logic             out_map_active;
    logic [31:0]      sf, inv, fen, fval, img, pol, men, mval, ex;
    logic [33:0]      exp_q[$];
    logic [33:0]      note;
    logic [7:0]       codes[16] = '{8'h00, 8'h01, 8'h05, 8'h10, 8'h41, 8'h42, 8'h43, 8'h44,
                                    8'h45, 8'h46, 8'h47, 8'h48, 8'h80, 8'hc8, 8'h90, 8'h20};
    int               n_fail = 0;
    int               cmp_count = 0;

    always #50 sys_clk = ~sys_clk;

    iroc_field i_field (.lvl(lvl), .phys_in(phys_in), .hall_in(hall_in), .enc_in(enc_in),
                        .usb_power_in(usb_power_in), .eth_active_in(eth_active_in));
    iroc_top #(.N_OUT(N_OUT), .N_MAP(32)) i_dut (
        .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .phys_in(phys_in),
        .hall_in(hall_in), .enc_in(enc_in), .usb_power_in(usb_power_in), .eth_active_in(eth_active_in),
        .route_level(route), .in_image(in_image), .brake_out(brake_out), .dout(dout),
        .out_map_active(out_map_active));

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // One APB transfer; the expected answer is noted before the request goes out
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                       input logic er);
        int k;
        @(posedge sys_clk);
        exp_q.push_back({wr, er, e});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20) begin
            n_fail++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask

    // Room for the synchroniser and the image flop, then look at settled outputs
    task automatic settle();
        repeat (5) @(posedge sys_clk);
        #1;
    endtask

    task automatic new_src();
        @(posedge sys_clk);
        lvl <= 24'($urandom);
        settle();
    endtask

    // Watcher: every completed transfer takes the oldest note off the queue
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                note = exp_q.pop_front();
                check(32'(pslverr), 32'(note[32]));
                if (!note[33])
                    check(prdata, note[31:0]);
            end
        end
    end

    // Normal input path with function enable, inversion and forcing
    function automatic logic [31:0] norm();
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 16; i++)
            r[16+i] = fen[i] ? fval[i] : lvl[i] ^ inv[i];
        for (int i = 0; i < 3; i++)
            r[i] = sf[i] & r[16+i];
        return r;
    endfunction

    // Level chosen by a source code; undefined low seven bits give zero, which bit 7 then inverts
    function automatic logic sel(input logic [7:0] c);
        logic v;
        v = 1'b0;
        if (c[6:0] >= 7'h01 && c[6:0] <= 7'h10)
            v = lvl[c[6:0] - 7'h01];
        if (c[6:0] >= 7'h41 && c[6:0] <= 7'h48)
            v = lvl[c[6:0] - 7'h31];
        return v ^ c[7];
    endfunction

    // Table entry loaded when mapping is switched on
    function automatic logic [31:0] pre(input int n);
        logic [7:0] c;
        c = (n >= 17) ? 8'(n - 16) : (n <= 3 && sf[n-1]) ? 8'(n) : 8'h00;
        if (c != 8'h00 && inv[(n >= 17) ? n - 17 : n - 1])
            c = c | 8'h80;
        return {24'h0, c};
    endfunction

    function automatic logic [31:0] app();
        logic [31:0] r;
        r = (men & mval) | (~men & (img ^ pol));
        r[15:1] = 15'h0;
        return r;
    endfunction

    initial begin
        void'($urandom(30038));
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        // Reset values, reserved and read-only places, an unmapped address
        for (int a = 0; a <= 'h34; a += 4)
            rd(12'(a), 32'h0);
        rd(12'h17c, 32'h0);
        wr(`IROC_OFS_APPLIED, 32'hffff_ffff);
        wr(`IROC_OFS_OUT_UNUSED, 32'hffff_ffff);
        rd(`IROC_OFS_OUT_UNUSED, 32'h0);
        apb(1'b1, 12'h040, 32'hffff_ffff, 32'h0, 1'b1);
        apb(1'b0, 12'h040, 32'h0, 32'h0, 1'b1);
        // Normal path
        sf = 32'h7;
        inv = $urandom;
        fen = $urandom;
        fval = $urandom;
        wr(`IROC_OFS_SF_EN, sf);
        wr(`IROC_OFS_IN_INVERT, inv);
        wr(`IROC_OFS_FORCE_EN, fen);
        wr(`IROC_OFS_FORCE_VAL, fval);
        new_src();
        check(in_image, norm());
        rd(`IROC_OFS_IN_IMAGE, norm());
        // Enable value other than one keeps mapping off, so no preload
        fen = 32'h0;
        wr(`IROC_OFS_FORCE_EN, fen);
        wr(`IROC_OFS_IN_MAP_EN, 32'h2);
        settle();
        check(in_image, norm());
        rd(12'h140, 32'h0);
        // Switching on preloads the table and keeps the image as before
        wr(`IROC_OFS_IN_MAP_EN, 32'h1);
        for (int n = 1; n <= 32; n++)
            rd(12'(12'h100 + 4 * (n - 1)), pre(n));
        settle();
        check(in_image, norm());
        ex = norm();
        inv = ~inv;
        sf = 32'h0;
        fen = 32'hffff_ffff;
        wr(`IROC_OFS_IN_INVERT, inv);
        wr(`IROC_OFS_SF_EN, sf);
        wr(`IROC_OFS_FORCE_EN, fen);
        settle();
        check(in_image, ex);
        // Every kind of source code into the lowest and highest image bits
        foreach (codes[j]) begin
            wr(12'h100, {24'h0, codes[j]});
            wr(12'h17c, {24'h0, codes[j] ^ 8'h80});
            new_src();
            check(32'(in_image[0]), 32'(sel(codes[j])));
            check(32'(in_image[31]), 32'(sel(codes[j] ^ 8'h80)));
        end
        wr(`IROC_OFS_IN_MAP_EN, 32'h0);
        settle();
        check(in_image, norm());
        // Output stage: polarity, manual override, readback
        for (int k = 0; k < 4; k++) begin
            img = $urandom;
            pol = $urandom;
            men = (k == 0) ? 32'h1 : $urandom;
            mval = $urandom;
            wr(`IROC_OFS_OUT_IMAGE, img);
            wr(`IROC_OFS_OUT_POL, pol);
            wr(`IROC_OFS_MAN_EN, men);
            wr(`IROC_OFS_MAN_VAL, mval);
            settle();
            ex = app();
            rd(`IROC_OFS_APPLIED, ex);
            check(32'(brake_out), 32'(ex[0]));
            check(32'(dout), 32'(ex[16 +: N_OUT]));
        end
        // Output mapping hands the outputs to the routing levels; brake stays
        wr(`IROC_OFS_OUT_MAP_EN, 32'h1);
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            route <= 4'($urandom);
            settle();
            check(32'(out_map_active), 32'h1);
            check(32'(dout), 32'(route));
            check(32'(brake_out), 32'(ex[0]));
        end
        wr(`IROC_OFS_OUT_MAP_EN, 32'h3);
        settle();
        check(32'(out_map_active), 32'h0);
        check(32'(dout), 32'(ex[16 +: N_OUT]));
        rd(`IROC_OFS_OUT_MAP_EN, 32'h3);
        repeat (2) @(posedge sys_clk);
        check(32'(exp_q.size()), 32'h0);
        give_verdict();
    end
endmodule
